//--- pkg/ofs_params.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 32-bit APB, register byte address is four times its index.
// Notes:   Included by bare name.
`ifndef OFS_PARAMS_SVH
`define OFS_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define OFS_IDX_EN_HI 8'h0c
`define OFS_IDX_EN_LO 8'h0d
`define OFS_IDX_CTRL  8'h10
`define OFS_IDX_DIV   8'h11
`define OFS_IDX_BIAS  8'h12
`define OFS_IDX_FIFO  8'h13
`define OFS_IDX_STAT  8'h14
`define OFS_IDX_SLOT0 8'h20

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define OFS_CTRL_POL   2
`define OFS_CTRL_OSC   3
`define OFS_CTRL_RAW   4
`define OFS_CTRL_FLUSH 5
`define OFS_CTRL_RST   5'h00
`define OFS_DIV_RST    16'h0140
`define OFS_BIAS_RST   8'h55
`define OFS_DIV_MIN    16'h000b
`define OFS_DIV_MAX    16'h8000
`define OFS_TAG_DARK   4'ha
`define OFS_TAG_EMPTY  4'he

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OFS_CLK_HZ   40000000
`define OFS_OSC0_HZ  32000
`define OFS_OSC1_HZ  32768
`define OFS_OSC0_CYC (`OFS_CLK_HZ / `OFS_OSC0_HZ)
`define OFS_OSC1_CYC (`OFS_CLK_HZ / `OFS_OSC1_HZ)

`endif

//--- pkg/ofs_pkg.sv
// Purpose: Types shared by the frame sequencer.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in ofs_params.svh.
package ofs_pkg;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_PICK  = 7'b0000010,
		ST_CONV  = 7'b0000100,
		ST_WAIT  = 7'b0001000,
		ST_ADV   = 7'b0010000,
		ST_PUSH1 = 7'b0100000,
		ST_PUSH2 = 7'b1000000
	} ofs_state_t;

	typedef enum logic [1:0] {
		SCH_CENTER = 2'h0,
		SCH_FORWARD = 2'h1,
		SCH_DIRECT = 2'h2,
		SCH_RSVD = 2'h3
	} ofs_scheme_t;

	typedef struct packed {
		logic [22:0] analog;
		logic        simul;
		logic [2:0]  drv;
		logic [2:0]  aver;
		ofs_scheme_t scheme;
	} ofs_slot_cfg_t;

	typedef struct packed {
		logic [3:0]  tag;
		logic [19:0] data;
	} ofs_word_t;

endpackage : ofs_pkg

//--- rtl/ofs_top.sv
// Purpose: Optical frame sequencer with tagged sample FIFO.
// Assumes: ADC and LED analog run on clk_sys; APB slave, no waits.
// Notes:   Overview of operation below.
//
// Overview of operation
// - External clock divided by frame_divider starts frames
// - Each photodiode input has own bias field
// - Frame holds one to nine enabled measurements
// - Nine slots each hold independent settings
// - Pulse up to three drivers, sequential or together
// - Centered: ambient, exposure, ambient; one result
// - Forward: ambient then exposure; difference pushed
// - Direct ambient measurement with no LED driven
// - Disabled slots skipped, no conversion or entry
// - Enabled slots visited in ascending order
// - Frame source field selects divider or trigger
// - Averaging pushes one mean word per channel per enabled slot
// - FIFO holds 256 entries with 4-bit tag
// - Slot nine enable high bit7, others low
// - Tag occupies top four bits of word
// - Low 20 bits signed left-justified sample
// - Channel one then channel two, fixed order
// - Config change aborts frame, restarts with new
// - Raw select pushes raw ambient and exposure
// - Trigger edge per polarity starts a frame
// - Divider 11 to 32768; oscillator rate select
// - Empty FIFO read returns empty marker tag
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "ofs_params.svh"

module ofs_top #(
	parameter int SLOTS = 9,
	parameter int DEPTH = 256
) (
	input  logic                  clk_sys,
	input  logic                  srst,
	input  logic                  psel,
	input  logic                  penable,
	input  logic                  pwrite,
	input  logic [11:0]           paddr,
	input  logic [31:0]           pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  logic                  frame_trigger_in,
	output logic                  adc_start,
	input  logic                  adc_done,
	input  logic [19:0]           adc_ch1,
	input  logic [19:0]           adc_ch2,
	output logic [2:0]            led_drive,
	output logic                  ambient_phase,
	output logic [7:0]            photodiode_bias_select,
	output ofs_pkg::ofs_slot_cfg_t slot_cfg_out,
	output logic                  active
);

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]             en_hi_q;
	logic [7:0]             en_lo_q;
	logic [4:0]             ctrl_q;
	logic [15:0]            div_q;
	logic [7:0]             bias_q;
	ofs_pkg::ofs_slot_cfg_t slot_q [SLOTS];
	logic [31:0]            prdata_q;
	logic                   err_q;
	logic                   pop_ok_q;
	logic [7:0]             idx;
	logic [7:0]             sidx;
	logic [31:0]            rdata_d;
	logic                   hit;
	logic                   wr;
	logic                   cfg_chg;
	logic                   pop;
	logic                   flush;
	logic [8:0]             en;
	logic [AW:0]            cnt_q;
	logic [23:0]            head;
	ofs_pkg::ofs_state_t    st_q;
	logic [3:0]             cur_q;

	assign idx = paddr[9:2];
	assign sidx = idx - `OFS_IDX_SLOT0;
	assign wr = psel & penable & pwrite & hit;
	assign cfg_chg = wr & (idx != `OFS_IDX_FIFO) & (idx != `OFS_IDX_STAT);
	assign flush = wr & (idx == `OFS_IDX_CTRL) & pwdata[`OFS_CTRL_FLUSH];
	assign pop = psel & penable & ~pwrite & pop_ok_q;
	assign en = {en_hi_q[7], en_lo_q};
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = err_q & psel & penable;
	assign photodiode_bias_select = bias_q;

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		hit = (paddr[11:10] == 2'h0);
		if (idx >= `OFS_IDX_SLOT0 && sidx < 8'(SLOTS))
			rdata_d = slot_q[sidx[3:0]];
		else
			case (idx)
				`OFS_IDX_EN_HI: rdata_d = {24'h0, en_hi_q[7], 7'h00};
				`OFS_IDX_EN_LO: rdata_d = {24'h0, en_lo_q};
				`OFS_IDX_CTRL:  rdata_d = {27'h0, ctrl_q};
				`OFS_IDX_DIV:   rdata_d = {16'h0, div_q};
				`OFS_IDX_BIAS:  rdata_d = {24'h0, bias_q};
				`OFS_IDX_FIFO:
					rdata_d = (cnt_q != '0) ? {8'h00, head} :
						{8'h00, `OFS_TAG_EMPTY, 20'h00000};
				`OFS_IDX_STAT:
					rdata_d = {16'h0, 7'(cnt_q), st_q != ofs_pkg::ST_IDLE,
						4'h0, cur_q};
				default:        hit = 1'b0;
			endcase
	end

	// Read data is captured in the setup cycle so prdata comes from a flop.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			pop_ok_q <= 1'b0;
		end
		else if (psel & ~penable)
		begin
			prdata_q <= rdata_d;
			err_q <= ~hit;
			pop_ok_q <= hit & ~pwrite & (idx == `OFS_IDX_FIFO) & (cnt_q != '0);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			en_hi_q <= 8'h00;
			en_lo_q <= 8'h00;
			ctrl_q <= `OFS_CTRL_RST;
			div_q <= `OFS_DIV_RST;
			bias_q <= `OFS_BIAS_RST;
			for (int i = 0; i < SLOTS; i++)
				slot_q[i] <= '0;
		end
		else if (wr)
		begin
			if (idx >= `OFS_IDX_SLOT0 && sidx < 8'(SLOTS))
				slot_q[sidx[3:0]] <= pwdata;
			case (idx)
				`OFS_IDX_EN_HI: en_hi_q <= {pwdata[7], 7'h00};
				`OFS_IDX_EN_LO: en_lo_q <= pwdata[7:0];
				`OFS_IDX_CTRL:  ctrl_q <= pwdata[4:0];
				`OFS_IDX_DIV:   div_q <= pwdata[15:0];
				`OFS_IDX_BIAS:  bias_q <= pwdata[7:0];
				default:        ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	logic [2:0]  trg_q;
	logic        lvl_q;
	logic        lvl_p_q;
	logic [10:0] osc_q;
	logic [10:0] osc_top;
	logic        osc_tick;
	logic [15:0] fcnt_q;
	logic [15:0] divv;
	logic        rise;
	logic        fall;
	logic        tick;
	logic        sof;
	logic        sofp_q;

	// The trigger level only changes once two late stages agree.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			trg_q <= 3'h0;
			lvl_q <= 1'b0;
			lvl_p_q <= 1'b0;
		end
		else
		begin
			trg_q <= {trg_q[1:0], frame_trigger_in};
			if (trg_q[1] == trg_q[2])
				lvl_q <= trg_q[2];
			lvl_p_q <= lvl_q;
		end
	end

	assign rise = lvl_q & ~lvl_p_q;
	assign fall = ~lvl_q & lvl_p_q;
	assign osc_top = ctrl_q[`OFS_CTRL_OSC] ? 11'(`OFS_OSC1_CYC - 1) :
		11'(`OFS_OSC0_CYC - 1);
	// A switch to the faster rate can leave the count above the new top, so wrap on >=.
	assign osc_tick = (osc_q >= osc_top);
	assign divv = (div_q < `OFS_DIV_MIN) ? `OFS_DIV_MIN :
		(div_q > `OFS_DIV_MAX) ? `OFS_DIV_MAX : div_q;
	assign tick = (ctrl_q[1:0] == 2'h2) ? rise :
		(ctrl_q[1:0] == 2'h0) ? osc_tick : 1'b0;
	assign sof = (ctrl_q[1:0] == 2'h1) ?
		(ctrl_q[`OFS_CTRL_POL] ? rise : fall) :
		(tick && fcnt_q >= divv - 16'h1);

	always_ff @(posedge clk_sys)
	begin
		if (srst || osc_tick)
			osc_q <= 11'h000;
		else
			osc_q <= osc_q + 11'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || cfg_chg)
			fcnt_q <= 16'h0;
		else if (tick)
			fcnt_q <= (fcnt_q >= divv - 16'h1) ? 16'h0 : fcnt_q + 16'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			sofp_q <= 1'b0;
		else if (sof || cfg_chg)
			sofp_q <= 1'b1;
		else if (st_q == ofs_pkg::ST_IDLE)
			sofp_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Measurement sequencer
	// ----------------------------------------------------------------
	ofs_pkg::ofs_slot_cfg_t cfg;
	logic [1:0]         ph_q;
	logic [1:0]         last_ph;
	logic [2:0]         left_q;
	logic [7:0]         pcnt_q;
	logic               expo;
	logic               more_drv;
	logic [2:0]         led_d;
	logic signed [21:0] amb1_q, amb2_q, exp1_q, exp2_q;
	logic signed [21:0] corr1, corr2;
	logic signed [27:0] acc1_q, acc2_q, acc1_n, acc2_n, avg1, avg2;
	logic [23:0]        w1_q, w2_q;
	logic               fin_q;
	logic               start_q;
	logic [2:0]         led_q;
	logic               ambp_q;
	logic [3:0]         tag;

	assign cfg = (cur_q < 4'(SLOTS)) ? slot_q[cur_q] : '0;
	assign tag = cur_q + 4'h1;
	assign last_ph = (cfg.scheme == ofs_pkg::SCH_CENTER) ? 2'h2 :
		(cfg.scheme == ofs_pkg::SCH_FORWARD) ? 2'h1 : 2'h0;
	assign expo = (ph_q == 2'h1);
	assign more_drv = expo & ~cfg.simul & ((left_q & (left_q - 3'h1)) != 3'h0);
	// Sequential drive lights the lowest driver still pending.
	assign led_d = ~expo ? 3'h0 : cfg.simul ? cfg.drv :
		(left_q & (~left_q + 3'h1));

	always_comb
	begin
		unique case (cfg.scheme)
			ofs_pkg::SCH_CENTER:
			begin
				corr1 = exp1_q - (amb1_q >>> 1);
				corr2 = exp2_q - (amb2_q >>> 1);
			end
			ofs_pkg::SCH_FORWARD:
			begin
				corr1 = exp1_q - amb1_q;
				corr2 = exp2_q - amb2_q;
			end
			default:
			begin
				corr1 = amb1_q;
				corr2 = amb2_q;
			end
		endcase
	end

	assign acc1_n = acc1_q + 28'(corr1);
	assign acc2_n = acc2_q + 28'(corr2);
	assign avg1 = acc1_n >>> cfg.aver;
	assign avg2 = acc2_n >>> cfg.aver;

	always_ff @(posedge clk_sys)
	begin
		start_q <= 1'b0;
		if (srst || cfg_chg)
		begin
			st_q <= ofs_pkg::ST_IDLE;
			cur_q <= 4'h0;
			ph_q <= 2'h0;
			left_q <= 3'h0;
			pcnt_q <= 8'h00;
			led_q <= 3'h0;
			ambp_q <= 1'b0;
			fin_q <= 1'b0;
			{amb1_q, amb2_q, exp1_q, exp2_q} <= '0;
			{acc1_q, acc2_q} <= '0;
			{w1_q, w2_q} <= '0;
		end
		else
		begin
			unique case (st_q)
				ofs_pkg::ST_IDLE:
					if (sofp_q)
					begin
						cur_q <= 4'h0;
						st_q <= ofs_pkg::ST_PICK;
					end
				ofs_pkg::ST_PICK:
					if (cur_q >= 4'(SLOTS))
						st_q <= ofs_pkg::ST_IDLE;
					else if (en[cur_q])
					begin
						ph_q <= 2'h0;
						pcnt_q <= 8'h00;
						left_q <= cfg.drv;
						{amb1_q, amb2_q, exp1_q, exp2_q} <= '0;
						{acc1_q, acc2_q} <= '0;
						st_q <= ofs_pkg::ST_CONV;
					end
					else
						cur_q <= cur_q + 4'h1;
				ofs_pkg::ST_CONV:
				begin
					start_q <= 1'b1;
					led_q <= led_d;
					ambp_q <= ~expo;
					st_q <= ofs_pkg::ST_WAIT;
				end
				ofs_pkg::ST_WAIT:
					if (adc_done)
					begin
						led_q <= 3'h0;
						if (expo)
						begin
							exp1_q <= exp1_q + 22'(signed'(adc_ch1));
							exp2_q <= exp2_q + 22'(signed'(adc_ch2));
						end
						else
						begin
							amb1_q <= amb1_q + 22'(signed'(adc_ch1));
							amb2_q <= amb2_q + 22'(signed'(adc_ch2));
						end
						w1_q <= {expo ? tag : `OFS_TAG_DARK, adc_ch1};
						w2_q <= {expo ? tag : `OFS_TAG_DARK, adc_ch2};
						fin_q <= 1'b0;
						st_q <= ctrl_q[`OFS_CTRL_RAW] ? ofs_pkg::ST_PUSH1 :
							ofs_pkg::ST_ADV;
					end
				ofs_pkg::ST_ADV:
					if (more_drv)
					begin
						left_q <= left_q & (left_q - 3'h1);
						st_q <= ofs_pkg::ST_CONV;
					end
					else if (ph_q != last_ph)
					begin
						ph_q <= ph_q + 2'h1;
						left_q <= cfg.drv;
						st_q <= ofs_pkg::ST_CONV;
					end
					else
					begin
						ph_q <= 2'h0;
						left_q <= cfg.drv;
						pcnt_q <= pcnt_q + 8'h1;
						acc1_q <= acc1_n;
						acc2_q <= acc2_n;
						{amb1_q, amb2_q, exp1_q, exp2_q} <= '0;
						if (pcnt_q != (8'h1 << cfg.aver) - 8'h1)
							st_q <= ofs_pkg::ST_CONV;
						else if (ctrl_q[`OFS_CTRL_RAW])
						begin
							cur_q <= cur_q + 4'h1;
							st_q <= ofs_pkg::ST_PICK;
						end
						else
						begin
							w1_q <= {tag, avg1[19:0]};
							w2_q <= {tag, avg2[19:0]};
							fin_q <= 1'b1;
							st_q <= ofs_pkg::ST_PUSH1;
						end
					end
				ofs_pkg::ST_PUSH1:
					st_q <= ofs_pkg::ST_PUSH2;
				ofs_pkg::ST_PUSH2:
					if (fin_q)
					begin
						cur_q <= cur_q + 4'h1;
						st_q <= ofs_pkg::ST_PICK;
					end
					else
						st_q <= ofs_pkg::ST_ADV;
				default:
					st_q <= ofs_pkg::ST_IDLE;
			endcase
		end
	end

	assign adc_start = start_q;
	assign led_drive = led_q;
	assign ambient_phase = ambp_q;
	assign slot_cfg_out = cfg;
	assign active = (st_q != ofs_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// Sample FIFO
	// ----------------------------------------------------------------
	// A full FIFO drops new words rather than stall the analog timing.
	logic [23:0]   mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic          push;
	logic          do_push;
	logic [23:0]   push_word;

	assign push = (st_q == ofs_pkg::ST_PUSH1) | (st_q == ofs_pkg::ST_PUSH2);
	assign push_word = (st_q == ofs_pkg::ST_PUSH1) ? w1_q : w2_q;
	assign do_push = push & (cnt_q != (AW + 1)'(DEPTH));
	assign head = mem_q[rp_q];

	always_ff @(posedge clk_sys)
	begin
		if (do_push)
			mem_q[wp_q] <= push_word;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || flush)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(pop);
		end
	end

endmodule : ofs_top

//--- tb/ofs_sva.sv
// Purpose: Port-level checks for the frame sequencer.
// Assumes: One clock, srst synchronous and active high.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`include "ofs_params.svh"
module ofs_sva (
	input logic                   clk_sys,
	input logic                   srst,
	input logic                   psel,
	input logic                   penable,
	input logic                   pwrite,
	input logic [11:0]            paddr,
	input logic [31:0]            pwdata,
	input logic                   pslverr,
	input logic                   adc_start,
	input logic [2:0]             led_drive,
	input logic                   ambient_phase,
	input logic [7:0]             photodiode_bias_select,
	input ofs_pkg::ofs_slot_cfg_t slot_cfg_out,
	input logic                   active
);
	// ------------------------------------------
	// Checks
	// ------------------------------------------
	localparam logic [11:0] ADDR_BIAS = 12'({`OFS_IDX_BIAS, 2'b00});
	localparam logic [11:0] ADDR_FIFO = 12'({`OFS_IDX_FIFO, 2'b00});
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	start_pulse_a: assert property (adc_start |=> !adc_start)
		else $error("conversion start wider than one cycle");
	idle_quiet_a: assert property (!active |-> !adc_start && led_drive == 3'h0)
		else $error("activity outside a frame");
	ambient_dark_a: assert property (ambient_phase |-> led_drive == 3'h0)
		else $error("drivers lit in an ambient conversion");
	direct_dark_a: assert property (active && slot_cfg_out.scheme == ofs_pkg::SCH_DIRECT
		|-> led_drive == 3'h0) else $error("drivers lit in a direct ambient slot");
	lit_exposure_a: assert property (adc_start && !ambient_phase
		&& slot_cfg_out.scheme != ofs_pkg::SCH_DIRECT |-> led_drive != 3'h0)
		else $error("exposure started with no driver");
	bias_write_a: assert property (psel && penable && pwrite && paddr == ADDR_BIAS
		|=> photodiode_bias_select == $past(pwdata[7:0])) else $error("bias not written");
	bias_reset_a: assert property ($fell(srst) |-> photodiode_bias_select == `OFS_BIAS_RST)
		else $error("bias reset value wrong");
	unmapped_err_a: assert property (psel && penable && paddr[11:10] != 2'h0 |-> pslverr)
		else $error("unmapped access not refused");
	fifo_ok_a: assert property (psel && penable && paddr == ADDR_FIFO |-> !pslverr)
		else $error("data port access refused");
	cover property (adc_start && ambient_phase);
	cover property (psel && penable && pslverr);
	cover property ($fell(active));
endmodule : ofs_sva

//--- tb/ofs_adc_model.sv
// Purpose: Converter pair that answers each conversion start.
// Assumes: One start outstanding at a time.
// Notes:   Data lines toggle outside the done cycle, so stale values never match.
`timescale 1ns/1ps
module ofs_adc_model #(
	parameter logic [19:0] AMB1 = 20'h00064,
	parameter logic [19:0] AMB2 = 20'h00028,
	parameter logic [19:0] EXP1 = 20'h003e8,
	parameter logic [19:0] EXP2 = 20'h001f4
) (
	input  logic        clk_sys,
	input  logic        srst,
	input  logic        adc_start,
	input  logic        ambient_phase,
	input  logic        slow,
	output logic        adc_done,
	output logic [19:0] adc_ch1,
	output logic [19:0] adc_ch2
);
	logic [2:0]  wait_q;
	logic        amb_q;
	// One process owns every output, so reset gives the data lines a known toggling start.
	always_ff @(posedge clk_sys)
	begin
		adc_done <= 1'b0;
		adc_ch1 <= ~adc_ch1;
		adc_ch2 <= ~adc_ch2;
		if (srst)
		begin
			wait_q <= 3'h0;
			adc_ch1 <= 20'h00000;
			adc_ch2 <= 20'hfffff;
		end
		else if (adc_start)
		begin
			amb_q <= ambient_phase;
			wait_q <= slow ? 3'h6 : 3'h1;
		end
		else if (wait_q == 3'h1)
		begin
			adc_done <= 1'b1;
			adc_ch1 <= amb_q ? AMB1 : EXP1;
			adc_ch2 <= amb_q ? AMB2 : EXP2;
			wait_q <= 3'h0;
		end
		else if (wait_q != 3'h0)
			wait_q <= wait_q - 3'h1;
	end
endmodule : ofs_adc_model

//--- tb/optical_frame_sequencer_fifo_format_tb_top.sv
// Purpose: Self-checking bench for the frame sequencer.
// Assumes: Converter model answers every start; divider clamped to 11.
// Notes:   Every bus access leaves a note; the monitor compares in order.
`timescale 1ns/1ps
`include "ofs_params.svh"
module optical_frame_sequencer_fifo_format_tb_top;
	// ------------------------------------------
	// Signals
	// ------------------------------------------
	localparam logic [19:0] AMB1 = 20'h00064;
	localparam logic [19:0] AMB2 = 20'h00028;
	localparam logic [19:0] EXP1 = 20'h003e8;
	localparam logic [19:0] EXP2 = 20'h001f4;
	localparam logic [11:0] A_HI = 12'({`OFS_IDX_EN_HI, 2'b00});
	localparam logic [11:0] A_LO = 12'({`OFS_IDX_EN_LO, 2'b00});
	localparam logic [11:0] A_CT = 12'({`OFS_IDX_CTRL, 2'b00});
	localparam logic [11:0] A_DV = 12'({`OFS_IDX_DIV, 2'b00});
	localparam logic [11:0] A_BS = 12'({`OFS_IDX_BIAS, 2'b00});
	localparam logic [11:0] A_FF = 12'({`OFS_IDX_FIFO, 2'b00});
	localparam logic [11:0] A_SL = 12'({`OFS_IDX_SLOT0, 2'b00});
	localparam logic [31:0] EMPTY = {8'h0, `OFS_TAG_EMPTY, 20'h0};
	typedef struct packed {logic [31:0] d; logic cd; logic er;} ofs_note_t;
	logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic frame_trigger_in = 1'b0, slow = 1'b0, act_q = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h48;
	logic pready, pslverr, adc_start, adc_done, ambient_phase, active;
	logic [19:0] adc_ch1, adc_ch2;
	logic [2:0] led_drive;
	logic [7:0] photodiode_bias_select;
	ofs_pkg::ofs_slot_cfg_t slot_cfg_out;
	ofs_note_t notes[$], nt;
	int bad_count = 0, compares = 0, conv_cnt = 0, frames = 0, s, a, f0;
	always #12.5 clk_sys = ~clk_sys;
	ofs_top ofs_top_inst (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .frame_trigger_in, .adc_start, .adc_done, .adc_ch1,
		.adc_ch2, .led_drive, .ambient_phase, .photodiode_bias_select, .slot_cfg_out, .active);
	ofs_adc_model #(.AMB1(AMB1), .AMB2(AMB2), .EXP1(EXP1), .EXP2(EXP2)) ofs_adc_model_inst (
		.clk_sys, .srst, .adc_start, .ambient_phase, .slow, .adc_done, .adc_ch1, .adc_ch2);
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic print_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// Read data is the expected value; write data is only driven.
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
		input logic er);
		notes.push_back('{d, !w, er});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : xfer
	task automatic wait_idle();
		repeat (12) @(posedge clk_sys);
		while (active !== 1'b0)
			@(posedge clk_sys);
	endtask : wait_idle
	task automatic frame_test(input logic [1:0] sc, input logic [2:0] av, input logic raw,
		input logic [8:0] en, input logic pol);
		ofs_pkg::ofs_slot_cfg_t c;
		int b, k, f;
		logic [3:0] t;
		c = '{23'h0, 1'b0, 3'h1, av, ofs_pkg::ofs_scheme_t'(sc)};
		seed = xs(seed);
		slow <= seed[0];
		frame_trigger_in <= ~pol;
		xfer(1, A_HI, 32'h0, 0);
		xfer(1, A_LO, 32'h0, 0);
		for (k = 0; k < 9; k++)
			xfer(1, A_SL + 12'(4 * k), 32'(c), 0);
		xfer(1, A_CT, {26'h0, 1'b1, raw, 1'b0, pol, 2'h1}, 0);
		wait_idle();
		b = conv_cnt;
		xfer(1, A_HI, {24'h0, en[8], 7'h0}, 0);
		xfer(1, A_LO, {24'h0, en[7:0]}, 0);
		wait_idle();
		frame_trigger_in <= pol;
		repeat (8) @(posedge clk_sys);
		frame_trigger_in <= ~pol;
		wait_idle();
		check("conversions", 32'((2 * $countones(en) * (3 - sc)) << av), 32'(conv_cnt - b));
		for (f = 0; f < 2; f++)
			for (k = 0; k < 9; k++)
				if (en[k])
				begin
					t = 4'(k + 1);
					if (!raw)
					begin
						xfer(0, A_FF, {8'h0, t, sc == 2'h2 ? AMB1 : EXP1 - AMB1}, 0);
						xfer(0, A_FF, {8'h0, t, sc == 2'h2 ? AMB2 : EXP2 - AMB2}, 0);
					end
					else
					begin
						xfer(0, A_FF, {8'h0, `OFS_TAG_DARK, AMB1}, 0);
						xfer(0, A_FF, {8'h0, `OFS_TAG_DARK, AMB2}, 0);
						xfer(0, A_FF, {8'h0, t, EXP1}, 0);
						xfer(0, A_FF, {8'h0, t, EXP2}, 0);
					end
				end
		xfer(0, A_FF, EMPTY, 0);
		$display("test frame scheme %0d aver %0d raw %0d en %h done", sc, av, raw, en);
	endtask : frame_test
	always @(posedge clk_sys)
	begin
		if (adc_start === 1'b1)
			conv_cnt++;
		if (active === 1'b1 && act_q === 1'b0)
			frames++;
		act_q = active;
		if (psel && penable && pready === 1'b1)
		begin
			nt = notes.pop_front();
			check("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
			if (nt.cd)
				check("prdata", nt.d, prdata);
		end
	end
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		print_verdict();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		xfer(0, A_BS, 32'h55, 0);
		xfer(0, A_DV, 32'h140, 0);
		// Enable writes start frames, so every slot first gets one lit driver.
		for (s = 0; s < 9; s++)
			xfer(1, A_SL + 12'(4 * s), 32'h20, 0);
		xfer(0, A_SL + 12'h20, 32'h20, 0);
		xfer(1, A_HI, 32'hff, 0);
		xfer(0, A_HI, 32'h80, 0);
		xfer(1, A_LO, 32'ha5, 0);
		xfer(0, A_LO, 32'ha5, 0);
		xfer(1, A_DV, 32'hffff, 0);
		// Readback shows the stored value; the clamp acts only on the frame count.
		xfer(0, A_DV, 32'hffff, 0);
		xfer(1, A_DV, 32'h5, 0);
		xfer(0, A_DV, 32'h5, 0);
		xfer(1, A_BS, 32'he6, 0);
		xfer(0, A_BS, 32'he6, 0);
		xfer(1, 12'hc00, 32'h1, 1);
		xfer(1, A_HI, 32'h0, 0);
		xfer(1, A_LO, 32'h0, 0);
		xfer(1, A_CT, 32'h23, 0);
		wait_idle();
		xfer(0, A_FF, EMPTY, 0);
		$display("test registers done");
		for (s = 0; s < 3; s++)
			for (a = 0; a < 2; a++)
				frame_test(2'(s), 3'(a), 1'b0, 9'h001, a[0]);
		frame_test(2'h1, 3'h0, 1'b1, 9'h001, 1'b1);
		repeat (2)
		begin
			seed = xs(seed);
			frame_test(2'h1, 3'h0, 1'b0, seed[8:0] | 9'h100, 1'b1);
		end
		xfer(1, A_LO, 32'h1, 0);
		xfer(1, A_HI, 32'h0, 0);
		f0 = frames;
		xfer(1, A_CT, 32'h2, 0);
		repeat (176)
		begin
			repeat (4) @(posedge clk_sys);
			frame_trigger_in <= ~frame_trigger_in;
		end
		wait_idle();
		check("ext_frames", 32'h1, 32'(frames - f0 >= 8 && frames - f0 <= 10));
		$display("test external frame clock done");
		print_verdict();
	end
endmodule : optical_frame_sequencer_fifo_format_tb_top
bind ofs_top ofs_sva ofs_sva_inst (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pslverr, .adc_start, .led_drive, .ambient_phase, .photodiode_bias_select,
	.slot_cfg_out, .active);
